// *** irr_regs.vh ***
// Register map, field positions and reset values of the interrupt request router
`ifndef IRR_REGS_VH
`define IRR_REGS_VH

`define IRR_CTRL_ADDR 12'h000
`define IRR_ROUTE_ADDR 12'h004
`define IRR_PORTSEL_ADDR 12'h008
`define IRR_LINES_ADDR 12'h00C
`define IRR_STATUS_ADDR 12'h010
`define IRR_CLEAR_ADDR 12'h014
`define IRR_ENABLE_ADDR 12'h018
`define IRR_LEGACY_ADDR 12'h01C

`define IRR_CTRL_ADV_BIT 0
`define IRR_CTRL_MOUSE_BIT 1
`define IRR_CTRL_DISK0_BIT 2
`define IRR_CTRL_DISK1_BIT 3

`define IRR_CTRL_RESET 4'h0
`define IRR_ROUTE_RESET 32'h0000_0000
`define IRR_SERIAL_RESET 4'h4
`define IRR_PARALLEL_RESET 4'h7

`define IRR_STEER_MASK 16'hDEF8
`define IRR_IN_TIMER 0
`define IRR_IN_KBD 1
`define IRR_IN_CASCADE 2
`define IRR_IN_DISKETTE 6
`define IRR_IN_RTC 8
`define IRR_IN_MOUSE 12
`define IRR_IN_FPU 13
`define IRR_IN_DISK0 14
`define IRR_IN_DISK1 15
`define IRR_ADV_BASE 16

`endif

// *** irr_router.v ***
// Interrupt request router with APB register access
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "irr_regs.vh"

module irr_router #(
  parameter LINES = 8,
  parameter LEG_INPUTS = 16,
  parameter ADV_INPUTS = 24
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] slot1_int_n,
  input wire [3:0] slot2_int_n,
  input wire [3:0] slot3_int_n,
  input wire [3:0] slot4_int_n,
  input wire fw_int_n,
  input wire timer_req,
  input wire kbd_req,
  input wire cascade_req,
  input wire fpu_req,
  input wire mouse_req,
  input wire rtc_req,
  input wire diskette_req,
  input wire disk0_req,
  input wire disk1_req,
  input wire first_serial_port_req,
  input wire first_parallel_port_req,
  output wire routed_line_a_n,
  output wire routed_line_b_n,
  output wire routed_line_c_n,
  output wire routed_line_d_n,
  output wire routed_line_e_n,
  output wire routed_line_f_n,
  output wire routed_line_g_n,
  output wire routed_line_h_n,
  output reg [LEG_INPUTS-1:0] legacy_irq_q,
  output reg [ADV_INPUTS-1:0] adv_irq_q,
  output wire irq
);

  // ----------------------------------------
  // Routed lines, wired-OR of active-low pins
  // ----------------------------------------
  wire [LINES-1:0] line_n;
  wire [LINES-1:0] line_act;

  assign line_n[0] = slot3_int_n[3];
  assign line_n[1] = slot3_int_n[2];
  assign line_n[2] = fw_int_n & slot3_int_n[0] & slot4_int_n[1];
  assign line_n[3] = slot3_int_n[1] & slot4_int_n[0];
  assign line_n[4] = slot1_int_n[3] & slot2_int_n[2];
  assign line_n[5] = slot1_int_n[0] & slot2_int_n[1] & slot4_int_n[2];
  assign line_n[6] = slot1_int_n[1] & slot2_int_n[0] & slot4_int_n[3];
  assign line_n[7] = slot1_int_n[2] & slot2_int_n[3];

  assign line_act = ~line_n;

  assign routed_line_a_n = line_n[0];
  assign routed_line_b_n = line_n[1];
  assign routed_line_c_n = line_n[2];
  assign routed_line_d_n = line_n[3];
  assign routed_line_e_n = line_n[4];
  assign routed_line_f_n = line_n[5];
  assign routed_line_g_n = line_n[6];
  assign routed_line_h_n = line_n[7];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] ctrl_q;
  reg [31:0] route_q;
  reg [3:0] serial_sel_q;
  reg [3:0] parallel_sel_q;
  reg [LINES-1:0] status_q;
  reg [LINES-1:0] status_d;
  reg [LINES-1:0] enable_q;
  reg [LINES-1:0] line_prev_q;

  wire adv_mode;
  wire wr_en;
  wire [LINES-1:0] clr_bits;
  wire [LINES-1:0] rise;

  assign adv_mode = ctrl_q[`IRR_CTRL_ADV_BIT];
  assign wr_en = psel & penable & pwrite;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= `IRR_CTRL_RESET;
      route_q <= `IRR_ROUTE_RESET;
      serial_sel_q <= `IRR_SERIAL_RESET;
      parallel_sel_q <= `IRR_PARALLEL_RESET;
      enable_q <= 8'h00;
    end
    else if (wr_en)
    begin
      if (paddr == `IRR_CTRL_ADDR)
        ctrl_q <= pwdata[3:0];
      else if (paddr == `IRR_ROUTE_ADDR)
        route_q <= pwdata;
      else if (paddr == `IRR_PORTSEL_ADDR)
      begin
        serial_sel_q <= pwdata[3:0];
        parallel_sel_q <= pwdata[7:4];
      end
      else if (paddr == `IRR_ENABLE_ADDR)
        enable_q <= pwdata[LINES-1:0];
    end
  end

  // ----------------------------------------
  // Event status, set wins over clear
  // ----------------------------------------
  assign clr_bits = (wr_en && paddr == `IRR_CLEAR_ADDR) ? pwdata[LINES-1:0] : 8'h00;
  assign rise = line_act & ~line_prev_q;

  always @*
  begin
    status_d = (status_q & ~clr_bits) | rise;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_q <= 8'h00;
      line_prev_q <= 8'h00;
    end
    else
    begin
      status_q <= status_d;
      line_prev_q <= line_act;
    end
  end

  assign irq = |(status_q & enable_q);

  // ----------------------------------------
  // Legacy steering
  // ----------------------------------------
  wire [LEG_INPUTS-1:0] avail;
  wire [LEG_INPUTS-1:0] fixed;
  wire [LEG_INPUTS-1:0] steered;
  wire [LEG_INPUTS-1:0] serial_hot;
  wire [LEG_INPUTS-1:0] parallel_hot;

  assign avail = `IRR_STEER_MASK
    & ~({15'h0000, ctrl_q[`IRR_CTRL_MOUSE_BIT]} << `IRR_IN_MOUSE)
    & ~({15'h0000, ctrl_q[`IRR_CTRL_DISK0_BIT]} << `IRR_IN_DISK0)
    & ~({15'h0000, ctrl_q[`IRR_CTRL_DISK1_BIT]} << `IRR_IN_DISK1);

  assign serial_hot = (16'h0001 << serial_sel_q) & `IRR_STEER_MASK;
  assign parallel_hot = (16'h0001 << parallel_sel_q) & `IRR_STEER_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < LEG_INPUTS; gi = gi + 1)
    begin : g_steer
      wire [LINES-1:0] hit;
      genvar gl;
      for (gl = 0; gl < LINES; gl = gl + 1)
      begin : g_line
        assign hit[gl] = line_act[gl] && (route_q[gl*4 +: 4] == gi);
      end
      assign steered[gi] = avail[gi] & (|hit);
    end
  endgenerate

  assign fixed[`IRR_IN_TIMER] = timer_req;
  assign fixed[`IRR_IN_KBD] = kbd_req;
  assign fixed[`IRR_IN_CASCADE] = cascade_req;
  assign fixed[3] = 1'b0;
  assign fixed[4] = 1'b0;
  assign fixed[5] = 1'b0;
  assign fixed[`IRR_IN_DISKETTE] = diskette_req;
  assign fixed[7] = 1'b0;
  assign fixed[`IRR_IN_RTC] = rtc_req;
  assign fixed[9] = 1'b0;
  assign fixed[10] = 1'b0;
  assign fixed[11] = 1'b0;
  assign fixed[`IRR_IN_MOUSE] = mouse_req & ctrl_q[`IRR_CTRL_MOUSE_BIT];
  assign fixed[`IRR_IN_FPU] = fpu_req;
  assign fixed[`IRR_IN_DISK0] = disk0_req & ctrl_q[`IRR_CTRL_DISK0_BIT];
  assign fixed[`IRR_IN_DISK1] = disk1_req & ctrl_q[`IRR_CTRL_DISK1_BIT];

  wire [LEG_INPUTS-1:0] ports;
  wire [LEG_INPUTS-1:0] low_inputs;

  assign ports = ({LEG_INPUTS{first_serial_port_req}} & serial_hot)
    | ({LEG_INPUTS{first_parallel_port_req}} & parallel_hot);
  assign low_inputs = fixed | ports;

  // ----------------------------------------
  // Controller next values
  // ----------------------------------------
  reg [LEG_INPUTS-1:0] legacy_irq_d;
  reg [ADV_INPUTS-1:0] adv_irq_d;

  always @*
  begin
    legacy_irq_d = {LEG_INPUTS{1'b0}};
    adv_irq_d = {ADV_INPUTS{1'b0}};
    if (adv_mode)
    begin
      adv_irq_d = {line_act, low_inputs};
    end
    else
    begin
      legacy_irq_d = low_inputs | steered;
    end
  end

  // ----------------------------------------
  // Controller outputs
  // ----------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      legacy_irq_q <= {LEG_INPUTS{1'b0}};
      adv_irq_q <= {ADV_INPUTS{1'b0}};
    end
    else
    begin
      legacy_irq_q <= legacy_irq_d;
      adv_irq_q <= adv_irq_d;
    end
  end

  // ----------------------------------------
  // APB read and response
  // ----------------------------------------
  reg [31:0] rdata;
  reg mapped;
  reg [31:0] prdata_q;
  reg [31:0] prdata_d;

  always @*
  begin
    rdata = 32'h0000_0000;
    mapped = 1'b1;
    if (paddr == `IRR_CTRL_ADDR)
      rdata = {28'h0000000, ctrl_q};
    else if (paddr == `IRR_ROUTE_ADDR)
      rdata = route_q;
    else if (paddr == `IRR_PORTSEL_ADDR)
      rdata = {24'h000000, parallel_sel_q, serial_sel_q};
    else if (paddr == `IRR_LINES_ADDR)
      rdata = {24'h000000, line_act};
    else if (paddr == `IRR_STATUS_ADDR)
      rdata = {24'h000000, status_q};
    else if (paddr == `IRR_CLEAR_ADDR)
      rdata = 32'h0000_0000;
    else if (paddr == `IRR_ENABLE_ADDR)
      rdata = {24'h000000, enable_q};
    else if (paddr == `IRR_LEGACY_ADDR)
      rdata = {16'h0000, legacy_irq_q};
    else
      mapped = 1'b0;
  end

  // ----------------------------------------
  // Read data register
  // ----------------------------------------
  // Captured in the setup cycle so it stands through the access phase
  always @*
  begin
    prdata_d = prdata_q;
    if (psel && !penable && !pwrite)
      prdata_d = rdata;
    else if (!psel)
      prdata_d = 32'h0000_0000;
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else
      prdata_q <= prdata_d;
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

endmodule // irr_router
`default_nettype wire

// *** irr_router_monitor.sv ***
// Checker of the interrupt request router ports
`timescale 1ns/1ps
`default_nettype none
module irr_router_monitor #(
  parameter LEG_INPUTS = 16,
  parameter ADV_INPUTS = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] slot1_int_n,
  input wire logic [3:0] slot2_int_n,
  input wire logic [3:0] slot3_int_n,
  input wire logic [3:0] slot4_int_n,
  input wire logic fw_int_n,
  input wire logic timer_req,
  input wire logic kbd_req,
  input wire logic cascade_req,
  input wire logic fpu_req,
  input wire logic rtc_req,
  input wire logic routed_line_a_n,
  input wire logic routed_line_b_n,
  input wire logic routed_line_c_n,
  input wire logic routed_line_d_n,
  input wire logic routed_line_e_n,
  input wire logic routed_line_f_n,
  input wire logic routed_line_g_n,
  input wire logic routed_line_h_n,
  input wire logic [LEG_INPUTS-1:0] legacy_irq_q,
  input wire logic [ADV_INPUTS-1:0] adv_irq_q,
  input wire logic irq
);
  // ----------
  // Assertions
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_line_ab_map: assert property ({routed_line_a_n, routed_line_b_n} == slot3_int_n[3:2])
    else $error("lines A B wrong");
  a_line_c_share: assert property (routed_line_c_n == (fw_int_n & slot3_int_n[0] & slot4_int_n[1]))
    else $error("line C wrong");
  a_line_d_map: assert property (routed_line_d_n == (slot3_int_n[1] & slot4_int_n[0]))
    else $error("line D wrong");
  a_line_e_map: assert property (routed_line_e_n == (slot1_int_n[3] & slot2_int_n[2]))
    else $error("line E wrong");
  a_line_fgh_map: assert property ({routed_line_f_n, routed_line_g_n, routed_line_h_n} ==
    {slot1_int_n[0] & slot2_int_n[1] & slot4_int_n[2], slot1_int_n[1] & slot2_int_n[0] & slot4_int_n[3],
    slot1_int_n[2] & slot2_int_n[3]})
    else $error("lines F G H wrong");
  a_modes_apart: assert property (!(|legacy_irq_q && |adv_irq_q))
    else $error("both controllers driven");
  a_adv_upper: assert property ((adv_irq_q[23:16] & $past({routed_line_h_n, routed_line_g_n,
    routed_line_f_n, routed_line_e_n, routed_line_d_n, routed_line_c_n, routed_line_b_n, routed_line_a_n})) == 8'h00)
    else $error("upper input without line");
  a_reserved_fixed: assert property (({legacy_irq_q[13], legacy_irq_q[2:0]} &
    ~$past({fpu_req, cascade_req, kbd_req, timer_req})) == 4'h0)
    else $error("reserved input misused");
  a_rtc_fixed: assert property (legacy_irq_q[8] |-> $past(rtc_req))
    else $error("clock input misused");
  c_upper: cover property (|adv_irq_q[23:16]);
  c_shared: cover property (legacy_irq_q[9]);
  c_irq: cover property (irq);
endmodule // irr_router_monitor
bind irr_router irr_router_monitor #(.LEG_INPUTS(LEG_INPUTS), .ADV_INPUTS(ADV_INPUTS)) irr_router_monitor_i (.*);
`default_nettype wire

// *** irr_card_model.sv ***
// Add-in cards and onboard source driving the request pins
`timescale 1ns/1ps
`default_nettype none
module irr_card_model (
  input wire logic [16:0] want,
  output wire logic [3:0] slot1_int_n,
  output wire logic [3:0] slot2_int_n,
  output wire logic [3:0] slot3_int_n,
  output wire logic [3:0] slot4_int_n,
  output wire logic fw_int_n
);
  // Bit 0 of a slot is INTA, the pin a one-request card uses
  // Each request is a low level held until withdrawn
  assign {fw_int_n, slot4_int_n, slot3_int_n, slot2_int_n, slot1_int_n} = ~want;
endmodule // irr_card_model
`default_nettype wire

// *** tb_top.sv ***
// Self-checking testbench of the interrupt request router
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic [16:0] want = 17'h00000;
  logic [10:0] fx = 11'h000;
  int failures = 0, checks = 0;
  int mp [17] = '{5, 6, 7, 4, 6, 5, 4, 7, 2, 3, 1, 0, 3, 2, 5, 6, 2};
  int pin [8] = '{11, 10, 8, 9, 3, 0, 1, 2};
  wire [31:0] prdata;
  wire pready, pslverr, irq, fw_int_n;
  wire [3:0] slot1_int_n, slot2_int_n, slot3_int_n, slot4_int_n;
  wire [7:0] ln;
  wire [15:0] legacy_irq_q;
  wire [23:0] adv_irq_q;
  irr_card_model irr_card_model_i (.*);
  irr_router irr_router_i (.*, .timer_req(fx[0]), .kbd_req(fx[1]), .cascade_req(fx[2]), .fpu_req(fx[3]),
    .mouse_req(fx[4]), .rtc_req(fx[5]), .diskette_req(fx[6]), .disk0_req(fx[7]), .disk1_req(fx[8]),
    .first_serial_port_req(fx[9]), .first_parallel_port_req(fx[10]), .routed_line_a_n(ln[0]),
    .routed_line_b_n(ln[1]), .routed_line_c_n(ln[2]), .routed_line_d_n(ln[3]), .routed_line_e_n(ln[4]),
    .routed_line_f_n(ln[5]), .routed_line_g_n(ln[6]), .routed_line_h_n(ln[7]));
  // -----
  // Tasks
  // -----
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task w2;
    repeat (2) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task t_reset;
    apb(0, 12'h000, 0);
    chk(rd, 0);
    apb(0, 12'h008, 0);
    chk(rd, 32'h74);
    chk(irq, 0);
  endtask
  task t_map;
    for (int i = 0; i < 17; i++)
    begin
      want <= 17'h1 << i;
      w2;
      chk({24'h0, ln}, {24'h0, ~(8'h01 << mp[i])});
    end
    want <= 17'h10100;
    w2;
    chk({24'h0, ln}, 32'hFB);
    want <= 17'h1F7FF;
    w2;
    chk({24'h0, ln}, 32'h01);
  endtask
  task t_leg;
    want <= 17'h00800;
    for (int v = 0; v < 16; v++)
    begin
      apb(1, 12'h004, v);
      w2;
      chk(legacy_irq_q, 16'hDEF8 & (16'h1 << v));
      chk(adv_irq_q, 0);
    end
    apb(1, 12'h004, 32'h909);
    want <= 17'h10900;
    w2;
    chk(legacy_irq_q, 16'h0200);
    apb(0, 12'h00C, 0);
    chk(rd, 32'h05);
    apb(0, 12'h01C, 0);
    chk(rd, 32'h0200);
    apb(0, 12'h004, 0);
    chk(rd, 32'h909);
    want <= 0;
    w2;
    chk(legacy_irq_q, 0);
  endtask
  task t_fix;
    fx <= 11'h7FF;
    w2;
    chk(legacy_irq_q, 16'h21D7);
    apb(1, 12'h000, 32'hE);
    w2;
    chk(legacy_irq_q, 16'hF1D7);
    apb(1, 12'h008, 32'h75);
    w2;
    chk(legacy_irq_q, 16'hF1E7);
    apb(1, 12'h000, 32'hF);
    w2;
    chk(legacy_irq_q, 0);
    chk(adv_irq_q, 24'h00F1E7);
    fx <= 0;
  endtask
  task t_adv;
    for (int i = 0; i < 8; i++)
    begin
      want <= 17'h1 << pin[i];
      w2;
      chk(adv_irq_q, 24'h010000 << i);
    end
    want <= 0;
    apb(1, 12'h000, 0);
  endtask
  task t_irq;
    apb(1, 12'h014, 32'hFF);
    apb(0, 12'h010, 0);
    chk(rd, 0);
    apb(1, 12'h018, 32'h1);
    w2;
    chk(irq, 0);
    want <= 17'h00800;
    w2;
    chk(irq, 1);
    want <= 0;
    apb(0, 12'h010, 0);
    chk(rd, 1);
    apb(1, 12'h018, 0);
    w2;
    chk(irq, 0);
    apb(1, 12'h014, 32'h1);
    apb(1, 12'h018, 32'h1);
    w2;
    chk(irq, 0);
    apb(0, 12'h020, 0);
    chk({rd[30:0], er}, 32'h1);
  endtask
  task final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // --------
  // Sequence
  // --------
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  initial
  begin
    #100us;
    failures++;
    final_report;
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_map;
    t_leg;
    t_fix;
    t_adv;
    t_irq;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
